/* hw/fsp_pkg.sv */
// Constants, types and layout for the flash security protection block
package fsp_pkg;

  // Lock word locations in flash
  localparam logic [31:0] FSP_W1_ADDR  = 32'h0014_8000;
  localparam logic [31:0] FSP_W2_ADDR  = 32'h0014_8008;
  localparam logic [31:0] FSP_BGA_ADDR = 32'h0014_8004;
  localparam logic [31:0] FSP_BGB_ADDR = 32'h0014_800C;

  // Field positions in primary_lock_word
  localparam int FSP_RD_BIT  = 16;
  localparam int FSP_WR_BIT  = 17;
  localparam int FSP_LVL_BIT = 18;
  localparam int FSP_UP_LSB  = 19;

  // Sector geometry: 8 Kbyte sectors, sixteen sector slots, lock bits from FSP_SECT_FIRST up
  localparam int          FSP_SECT_SHIFT = 13;
  localparam int          FSP_SECT_W     = 4;
  localparam logic [3:0]  FSP_SECT_FIRST = 4'h4;
  localparam logic [2:0]  FSP_INTERNAL_VECTOR_BOOT_MODE     = 3'h0;

  // APB register offsets
  localparam int          FSP_AW       = 12;
  localparam logic [11:0] FSP_OFF_STAT = 12'h000;
  localparam logic [11:0] FSP_OFF_PRIM = 12'h004;
  localparam logic [11:0] FSP_OFF_SEC  = 12'h008;
  localparam logic [11:0] FSP_OFF_CTRL = 12'h00C;
  localparam logic [11:0] FSP_OFF_DCNT = 12'h010;

  // Control register bits, both self-clearing pulses
  localparam int FSP_CTRL_RELOAD = 0;
  localparam int FSP_CTRL_DCLR   = 1;

  // Reset values
  localparam logic [31:0] FSP_WORD_RST = 32'h0000_0000;
  localparam logic [15:0] FSP_DCNT_RST = 16'h0000;

  // Fetch sequencer, Gray coded from FSP_RST to FSP_DONE; the reload step back to FSP_GET1 flips both bits
  typedef enum logic [1:0] {
    FSP_RST  = 2'b00,
    FSP_GET1 = 2'b01,
    FSP_GET2 = 2'b11,
    FSP_DONE = 2'b10
  } fsp_fetch_e;

  // Flash access presented for checking
  typedef struct packed {
    logic        write;
    logic [31:0] addr;
  } fsp_acc_s;

endpackage

/* hw/fsp_guard.sv */
// Flash security decode, access checking and APB status slave
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module fsp_guard #(
  parameter logic [31:0] FLASH_LO  = 32'h000A_0000,
  parameter logic [31:0] FLASH_HI  = 32'h0015_0000,
  parameter logic [31:0] SECT_BASE = 32'h0014_0000
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [fsp_pkg::FSP_AW-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic [2:0]              device_mode_pins,
  output logic                         fetch_req,
  output logic      [31:0]             fetch_addr,
  input  wire logic                    fetch_ack,
  input  wire logic [31:0]             fetch_data,
  input  wire logic                    acc_valid,
  input  fsp_pkg::fsp_acc_s            acc_req,
  output logic                         acc_done,
  output logic                         acc_grant
);
  import fsp_pkg::*;

  // Parameters the address compare cannot serve
  if (FLASH_HI <= FLASH_LO) begin : g_bad_range
    $error("flash range is empty");
  end

  logic [2:0]  mode_s1_reg;
  logic [2:0]  mode_s2_reg;
  fsp_fetch_e  st_reg;
  fsp_fetch_e  st_next;
  logic [31:0] prim_reg;
  logic [31:0] sec_reg;
  logic [15:0] dcnt_reg;
  logic [15:0] dcnt_next;
  logic        fetch_req_reg;
  logic [31:0] fetch_addr_reg;
  logic        acc_done_reg;
  logic        acc_grant_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] rd_mux;

  // Mode pins are asynchronous straps, two stages before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_s1_reg <= FSP_INTERNAL_VECTOR_BOOT_MODE;
      mode_s2_reg <= FSP_INTERNAL_VECTOR_BOOT_MODE;
    end else begin
      mode_s1_reg <= device_mode_pins;
      mode_s2_reg <= mode_s1_reg;
    end
  end

  // APB phase decode
  wire apb_setup = psel & ~penable;
  wire apb_acc   = psel & penable & pready_reg;
  wire hit_stat  = paddr == FSP_OFF_STAT;
  wire hit_prim  = paddr == FSP_OFF_PRIM;
  wire hit_sec   = paddr == FSP_OFF_SEC;
  wire hit_ctrl  = paddr == FSP_OFF_CTRL;
  wire hit_dcnt  = paddr == FSP_OFF_DCNT;
  wire hit_ro    = hit_stat | hit_prim | hit_sec | hit_dcnt;
  wire bad_acc   = ~((hit_ro & ~pwrite) | hit_ctrl);
  wire wr_ctrl   = apb_acc & pwrite & hit_ctrl;
  wire reload    = wr_ctrl & pwdata[FSP_CTRL_RELOAD];
  wire dclr      = wr_ctrl & pwdata[FSP_CTRL_DCLR];

  // Fetch sequencer; a reload walks both words again
  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      FSP_RST:  st_next = FSP_GET1;
      FSP_GET1: if (fetch_ack) st_next = FSP_GET2;
      FSP_GET2: if (fetch_ack) st_next = FSP_DONE;
      FSP_DONE: if (reload) st_next = FSP_GET1;
    endcase
  end

  wire loaded  = st_reg == FSP_DONE;
  wire cap_w1  = st_reg == FSP_GET1 && fetch_ack;
  wire cap_w2  = st_reg == FSP_GET2 && fetch_ack;
  wire req_nxt = st_next == FSP_GET1 || st_next == FSP_GET2;

  // Word fetch; request held until the flash side acks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg         <= FSP_RST;
      fetch_req_reg  <= 1'b0;
      fetch_addr_reg <= FSP_W1_ADDR;
      prim_reg       <= FSP_WORD_RST;
      sec_reg        <= FSP_WORD_RST;
    end else begin
      st_reg         <= st_next;
      fetch_req_reg  <= req_nxt;
      fetch_addr_reg <= (st_next == FSP_GET2) ? FSP_W2_ADDR
                                              : FSP_W1_ADDR;
      if (cap_w1) begin
        prim_reg <= fetch_data;
      end
      if (cap_w2) begin
        sec_reg <= fetch_data;
      end
    end
  end

  // Protection mode from the upper half of the primary word
  wire internal_vector_boot_mode  = mode_s2_reg == FSP_INTERNAL_VECTOR_BOOT_MODE;
  wire up_ok   = prim_reg[31:FSP_UP_LSB] == '0;
  wire rd_prot = up_ok & prim_reg[FSP_RD_BIT] & ~internal_vector_boot_mode;
  wire wr_prot = up_ok & prim_reg[FSP_WR_BIT]
               & (~prim_reg[FSP_LVL_BIT] | ~internal_vector_boot_mode);

  // Sector lookup for the presented address
  wire [31:0] sect_off = acc_req.addr - SECT_BASE;
  wire        sect_in  = acc_req.addr >= SECT_BASE
                       && sect_off[31:FSP_SECT_SHIFT+FSP_SECT_W] == '0;
  wire [3:0]  sect_idx = sect_off[FSP_SECT_SHIFT +: FSP_SECT_W];
  // Low bits name no sector; sector_four obeys whatever was programmed
  wire sect_open = prim_reg[sect_idx]
                 | (sect_idx < FSP_SECT_FIRST);
  // Sector bits only matter while write protection is on
  wire wr_lock   = wr_prot & sect_in & ~sect_open;
  wire in_flash  = acc_req.addr >= FLASH_LO && acc_req.addr < FLASH_HI;
  // Flash is closed until the lock words are known
  wire deny      = in_flash & (~loaded
                 | (acc_req.write ? wr_lock : rd_prot));
  wire deny_ev   = acc_valid & deny;

  // Deny counter; a denial in the clear cycle still counts
  always_comb begin
    dcnt_next = dcnt_reg;
    if (dclr) begin
      dcnt_next = FSP_DCNT_RST;
    end
    if (deny_ev && dcnt_next != '1) begin
      dcnt_next = dcnt_next + 16'h0001;
    end
  end

  // Registered verdict, one cycle after the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_done_reg  <= 1'b0;
      acc_grant_reg <= 1'b0;
      dcnt_reg      <= FSP_DCNT_RST;
    end else begin
      acc_done_reg  <= acc_valid;
      acc_grant_reg <= acc_valid & ~deny;
      dcnt_reg      <= dcnt_next;
    end
  end

  // Read data selection; control reads as zero
  assign rd_mux = hit_stat ? {25'h000_0000, mode_s2_reg, internal_vector_boot_mode,
                              wr_prot, rd_prot, loaded} :
                  hit_prim ? prim_reg :
                  hit_sec  ? sec_reg :
                  hit_dcnt ? {16'h0000, dcnt_reg} : 32'h0000_0000;

  // One wait-free access phase; data latched during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg <= apb_setup;
      if (apb_setup) begin
        pslverr_reg <= bad_acc;
        prdata_reg  <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  assign prdata     = prdata_reg;
  assign pready     = pready_reg;
  assign pslverr    = pslverr_reg;
  assign fetch_req  = fetch_req_reg;
  assign fetch_addr = fetch_addr_reg;
  assign acc_done   = acc_done_reg;
  assign acc_grant  = acc_grant_reg;

  // Checks on the decode, fetch and deny counter
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_fetch_first:
    assert property (st_reg == FSP_GET1 |->
      fetch_req_reg && fetch_addr_reg == FSP_W1_ADDR)
    else $error("first fetch address wrong");

  chk_fetch_second:
    assert property (cap_w1 |=> fetch_req_reg
      && fetch_addr_reg == FSP_W2_ADDR && prim_reg == $past(fetch_data))
    else $error("second fetch wrong");

  chk_upper_nonzero:
    assert property (acc_valid && loaded
      && prim_reg[31:FSP_UP_LSB] != '0 |=> acc_done_reg && acc_grant_reg)
    else $error("nonzero upper bits still protect");

  chk_read_block:
    assert property (acc_valid && !acc_req.write && in_flash && loaded
      && up_ok && prim_reg[FSP_RD_BIT] && !internal_vector_boot_mode
      |=> acc_done_reg && !acc_grant_reg)
    else $error("protected read granted");

  chk_internal_vector_boot_mode_read:
    assert property (acc_valid && !acc_req.write && loaded && internal_vector_boot_mode
      |=> acc_grant_reg)
    else $error("boot mode read refused");

  chk_write_all:
    assert property (acc_valid && acc_req.write && in_flash && loaded
      && up_ok && prim_reg[FSP_LVL_BIT:FSP_WR_BIT] == 2'b01
      && sect_in && !sect_open |=> !acc_grant_reg)
    else $error("locked write granted");

  chk_write_internal_vector_boot_mode:
    assert property (acc_valid && acc_req.write && loaded
      && prim_reg[FSP_LVL_BIT] && internal_vector_boot_mode |=> acc_grant_reg)
    else $error("boot mode write refused");

  chk_sector_skip:
    assert property (acc_valid && acc_req.write && loaded
      && !prim_reg[FSP_WR_BIT] |=> acc_grant_reg)
    else $error("sector bits used without write bit");

  chk_low_sector:
    assert property (acc_valid && acc_req.write && loaded && sect_in
      && sect_idx < FSP_SECT_FIRST |=> acc_grant_reg)
    else $error("nonexistent sector locked");

  chk_cnt_set_wins:
    assert property (dclr && deny_ev |=> dcnt_reg == 16'h0001)
    else $error("denial lost on counter clear");

  cov_read_denied:
    cover property (acc_valid && !acc_req.write && deny ##1 acc_done_reg);
  cov_internal_vector_boot_mode_write:
    cover property (acc_valid && acc_req.write && internal_vector_boot_mode && wr_lock);
  cov_reload:
    cover property (loaded && reload ##1 st_reg == FSP_GET1);

endmodule // fsp_guard

/* tb/fsp_flash_model.sv */
// Flash responder that hands lock words to the fetch port
`timescale 1ns/1ps
module fsp_flash_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        slow,
  input  wire logic [31:0] word1,
  input  wire logic [31:0] word2,
  input  wire logic        fetch_req,
  input  wire logic [31:0] fetch_addr,
  output logic             fetch_ack,
  output logic [31:0]      fetch_data
);
  import fsp_pkg::*;
  logic        go_reg;
  logic [31:0] last_reg;
  wire         hit_w1 = (fetch_addr == FSP_W1_ADDR);
  wire         hit_w2 = (fetch_addr == FSP_W2_ADDR);
  // Only the two lock word places answer; a wrong fetch hangs
  assign fetch_ack  = fetch_req & go_reg & (hit_w1 | hit_w2);
  // Idle data is the inverse of the last cycle's data, so a sample one cycle stale never looks right
  assign fetch_data = fetch_ack ? (hit_w1 ? word1 : word2) : ~last_reg;
  // Stall every other cycle when slow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go_reg   <= 1'b0;
      last_reg <= 32'h0000_0000;
    end else begin
      go_reg   <= ~slow | ~go_reg;
      last_reg <= fetch_data;
    end
  end
endmodule // fsp_flash_model

/* tb/tb_top.sv */
// Self-checking bench for the flash security guard
`timescale 1ns/1ps
module tb_top;
  import fsp_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, fetch_addr, fetch_data, word1, word2, rd, a;
  logic [2:0]  device_mode_pins;
  logic        fetch_req, fetch_ack, acc_valid, acc_done, acc_grant, slow;
  logic        er, wr, ex;
  fsp_acc_s    acc_req;
  int          fail_count, cmp_count, cyc, seed, i, j, r;
  logic [31:0] ups [9] = '{32'h1, 32'h2, 32'h3, 32'h5, 32'h6, 32'h7,
                           32'h4, 32'h8, 32'h0};
  fsp_guard fsp_guard_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .device_mode_pins(device_mode_pins), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .fetch_ack(fetch_ack),
    .fetch_data(fetch_data), .acc_valid(acc_valid), .acc_req(acc_req),
    .acc_done(acc_done), .acc_grant(acc_grant));
  fsp_flash_model fsp_flash_model_inst (.pclk(pclk), .presetn(presetn),
    .slow(slow), .word1(word1), .word2(word2), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .fetch_ack(fetch_ack),
    .fetch_data(fetch_data));
  // 50 ns clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // Hang guard, well above the expected run length
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // One APB transfer; waits for pready, only the hang guard ends a wait
  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One access check, verdict looked at in its single done cycle
  task automatic acc(input logic w, input logic [31:0] ad, input logic e);
    @(posedge pclk);
    acc_valid <= 1'b1;
    acc_req <= {w, ad};
    @(posedge pclk);
    acc_valid <= 1'b0;
    #1;
    chk("acc_done", 1, acc_done);
    chk("acc_grant", e, acc_grant);
  endtask
  // Bounded wait for a whole word fetch to begin and end
  task automatic wait_fetch();
    int n;
    n = 0;
    while (!fetch_req && n < 20) begin
      @(posedge pclk);
      n++;
    end
    chk("fetch_start", 1, fetch_req);
    while (fetch_req && n < 60) begin
      @(posedge pclk);
      n++;
    end
    chk("fetch_req", 0, fetch_req);
  endtask
  function automatic logic exp_grant(logic [31:0] w, logic [2:0] m,
                                     logic wt, logic [31:0] ad);
    logic        uz;
    logic [31:0] k;
    uz = (w[31:19] == 13'h0);
    k = (ad - 32'h0014_0000) >> 13;
    if (ad < 32'h000A_0000 || ad >= 32'h0015_0000) return 1'b1;
    if (!wt) return !(uz && w[16] && m != FSP_INTERNAL_VECTOR_BOOT_MODE);
    return !(uz && w[17] && (!w[18] || m != FSP_INTERNAL_VECTOR_BOOT_MODE) &&
             ad >= 32'h0014_0000 && k >= 4 && !w[k[3:0]]);
  endfunction
  initial begin
    {psel, penable, pwrite, acc_valid, slow, presetn} = '0;
    {paddr, pwdata, acc_req, cyc, fail_count, cmp_count} = '0;
    device_mode_pins = 3'h1;
    seed = 94;
    word1 = 32'h0003_FFEF;
    word2 = 32'h0000_1234;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    acc(1'b0, 32'h000A_0000, 1'b0);
    wait_fetch();
    apb(1'b0, FSP_OFF_PRIM, 32'h0);
    chk("primary_lock_word", word1, rd);
    apb(1'b0, FSP_OFF_SEC, 32'h0);
    chk("secondary_lock_word", word2, rd);
    // Status after load: mode 001, both protections on, words loaded
    apb(1'b0, FSP_OFF_STAT, 32'h0);
    chk("status", 32'h0000_0017, rd);
    chk("pslverr", 0, er);
    // Loaded word blocks reads outside boot mode; second denial
    acc(1'b0, 32'h000A_0000, 1'b0);
    apb(1'b0, FSP_OFF_DCNT, 32'h0);
    chk("deny_count", 32'h0000_0002, rd);
    // Clear and a denial on one edge: the denial still counts
    fork
      apb(1'b1, FSP_OFF_CTRL, 32'h2);
      begin
        @(posedge pclk);
        acc(1'b0, 32'h000B_0000, 1'b0);
      end
    join
    apb(1'b0, FSP_OFF_DCNT, 32'h0);
    chk("deny_count", 32'h0000_0001, rd);
    apb(1'b1, FSP_OFF_CTRL, 32'h2);
    apb(1'b0, FSP_OFF_DCNT, 32'h0);
    chk("deny_count", 32'h0000_0000, rd);
    apb(1'b1, 12'h020, 32'h0);
    chk("pslverr", 1, er);
    for (i = 0; i < 36; i++) begin
      r = $random(seed);
      word1 = (ups[i % 9] << 16) | (r & 32'h0000_FFEF);
      word2 = $random(seed);
      slow <= r[20];
      device_mode_pins <= r[21] ? 3'h0 : r[24:22];
      apb(1'b1, FSP_OFF_CTRL, 32'h1);
      wait_fetch();
      repeat (4) @(posedge pclk);
      for (j = 0; j < 6; j++) begin
        r = $random(seed);
        wr = r[31];
        case (r[5:4])
          2'd0: a = 32'h0014_0000 + {r[3:0], 13'h0} + {r[12:8], 2'b00};
          2'd1: a = 32'h000A_0000 + r[17:0];
          2'd2: a = 32'h0015_0000 + r[15:0];
          default: a = 32'h0014_8000 + r[12:0];
        endcase
        ex = exp_grant(word1, device_mode_pins, wr, a);
        acc(wr, a, ex);
      end
    end
    wrap_up();
  end
endmodule // tb_top
